// *** rtqf_level_watch.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtqf_level_watch
    import rtqf_pkg::*;
(
    input  wire logic [QF_IDX_W-1:0] fill,
    input  wire logic                clk,
    input  wire logic                sys_rst,
    output logic                     low_cross,
    output logic                     high_cross
);
    logic is_low;
    logic is_high;
    logic was_low;
    logic was_high;

    assign is_low  = fill < LOW_THR;   // [R6]
    assign is_high = fill > HIGH_THR;  // [R6]

    // edge only, so a level that lingers raises one event
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            was_low    <= 1'b1;
            was_high   <= 1'b0;
            low_cross  <= 1'b0;
            high_cross <= 1'b0;
        end
        else
        begin
            was_low    <= is_low;
            was_high   <= is_high;
            low_cross  <= is_low && !was_low;    // [R16]
            high_cross <= is_high && !was_high;  // [R16]
        end
    end

endmodule
`default_nettype wire

// *** rtqf_pair_buf.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtqf_pair_buf
    import rtqf_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    input  wire logic [BUF_W-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [BUF_W-1:0] out_data,
    input  wire logic             out_ready
);
    logic [BUF_W-1:0] spare;
    logic             spare_valid;
    logic             take;
    logic             give;

    // second slot absorbs one word while the head stalls
    assign in_ready = !spare_valid;
    assign take     = in_valid && in_ready;
    assign give     = out_valid && out_ready;

    // head slot drives the outputs directly
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_valid   <= 1'b0;
            out_data    <= '0;
            spare_valid <= 1'b0;
            spare       <= '0;
        end
        else if (flush)
        begin
            out_valid   <= 1'b0;
            spare_valid <= 1'b0;
        end
        else if (spare_valid)
        begin
            if (give)
            begin
                out_data    <= spare;
                spare_valid <= 1'b0;
            end
        end
        else if (take)
        begin
            if (!out_valid || give)
            begin
                out_data  <= in_data;
                out_valid <= 1'b1;
            end
            else
            begin
                spare       <= in_data;
                spare_valid <= 1'b1;
            end
        end
        else if (give)
        begin
            out_valid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** rtqf_pkg.sv ***
// Function
// [R1] host clears queue before each transmit fill
// [R2] host bytes fill slots 0..23 circularly
// [R3] input counter counts every loaded byte
// [R4] output counter counts every consumed byte
// [R5] both counters are 12 bits wide
// [R6] interrupt below 6 and above 18 bytes
// [R7] sent bytes never exceed transmit length
// [R8] pulse when final byte reaches transmitter
// [R9] status register shows current byte count
// [R10] overflow flag on write into full queue
// [R11] low flag on low level while transmitting
// [R12] high flag on high level while receiving
// [R13] queue accessed only in continuous mode
// [R14] host writes transmit length before filling
// [R15] slot index counter mod 24, occupancy difference
// [R16] one interrupt per crossing, flags held
package rtqf_pkg;

    localparam int         QF_DEPTH    = 24;
    localparam int         QF_IDX_W    = 5;
    localparam int         CNT_W       = 12;
    localparam int         ADDR_W      = 6;
    localparam int         BYTE_W      = 8;
    localparam int         BUF_W       = 9;
    localparam int         TXLEN_HI_W  = 4;

    // register offsets
    localparam logic [5:0] OFF_STATUS  = 6'h1c;
    localparam logic [5:0] OFF_TXLEN_H = 6'h1d;
    localparam logic [5:0] OFF_TXLEN_L = 6'h1e;
    localparam logic [5:0] OFF_DATA    = 6'h1f;

    // command codes
    localparam logic [7:0] CMD_CLEAR   = 8'h0f;
    localparam logic [7:0] CMD_TX      = 8'h10;

    // status register fields
    localparam int         ST_FHIL     = 7;
    localparam int         ST_FLOL     = 6;
    localparam int         ST_FOVE     = 5;

    // levels and reset values
    localparam logic [4:0] LOW_THR     = 5'h06;
    localparam logic [4:0] HIGH_THR    = 5'h12;
    localparam logic [4:0] FULL_LVL    = 5'h18;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [11:0] RST_CNT    = 12'h000;

    // storage slot of a running byte counter
    function automatic logic [4:0] slot_of(input logic [11:0] cnt);
        logic [11:0] r;
        r = cnt % 12'h018;
        return r[4:0];
    endfunction

    // bytes held: difference of the two counters
    function automatic logic [4:0] fill_of(input logic [11:0] wr_cnt, input logic [11:0] rd_cnt);
        logic [11:0] d;
        d = wr_cnt - rd_cnt;
        return d[4:0];
    endfunction

endpackage

// *** rtqf_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtqf_props
    import rtqf_pkg::*;
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic              cmd_valid,
    input wire logic [BYTE_W-1:0] cmd_code,
    input wire logic              rx_active,
    input wire logic              rx_byte_valid,
    input wire logic              tx_ready,
    input wire logic [BYTE_W-1:0] reg_rdata,
    input wire logic [BYTE_W-1:0] tx_byte,
    input wire logic              tx_valid,
    input wire logic              tx_last_sent,
    input wire logic              tx_busy,
    input wire logic              queue_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // a quiet clear: no write in the same cycle that could set a flag
    sequence s_clear;
        cmd_valid && cmd_code == CMD_CLEAR && !reg_wr && !rx_byte_valid;
    endsequence
    sequence s_status_rd;
        reg_rd && reg_addr == OFF_STATUS && !rx_active;
    endsequence

    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_last_after_take: assert property (tx_last_sent |-> $past(tx_valid) && $past(tx_ready))
        else $error("last-byte pulse without a handshake");
    a_last_single: assert property (tx_last_sent |-> !tx_busy ##1 !tx_last_sent)
        else $error("last-byte pulse too long or busy kept");
    a_irq_single: assert property (queue_irq |=> !queue_irq)
        else $error("level interrupt longer than one cycle");
    a_byte_holds: assert property (tx_valid && !tx_ready && !cmd_valid |=> tx_valid && $stable(tx_byte))
        else $error("transmit byte dropped before taken");
    a_tx_starts: assert property (cmd_valid && cmd_code == CMD_TX |=> tx_busy)
        else $error("transmit command did not start");
    a_clear_empties: assert property (s_clear |=> !tx_busy && !tx_valid)
        else $error("clear left transmit state");
    // the command task leaves one idle edge before the status read
    a_clear_status: assert property (s_clear ##1 (!reg_wr && !rx_byte_valid) ##1 s_status_rd |=> reg_rdata == 8'h00)
        else $error("status not zero after clear");
endmodule
`default_nettype wire

// *** rtqf_queue.sv ***
`timescale 1ns/100ps
`default_nettype none
module rtqf_queue
    import rtqf_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [BYTE_W-1:0] reg_wdata,
    input  wire logic              cont_mode,
    input  wire logic              cmd_valid,
    input  wire logic [BYTE_W-1:0] cmd_code,
    input  wire logic              rx_active,
    input  wire logic              rx_byte_valid,
    input  wire logic [BYTE_W-1:0] rx_byte,
    input  wire logic              tx_ready,
    output logic      [BYTE_W-1:0] reg_rdata,
    output logic      [BYTE_W-1:0] tx_byte,
    output logic                   tx_valid,
    output logic                   tx_last_sent,
    output logic                   tx_busy,
    output logic                   queue_irq
);
    import rtqf_pkg::*;

    // all inputs come from the host interface logic on clk,
    // so none of them passes a synchroniser

    logic [BYTE_W-1:0]     store [0:QF_DEPTH-1];
    logic [CNT_W-1:0]      in_cnt;
    logic [CNT_W-1:0]      out_cnt;
    logic [CNT_W-1:0]      tx_len;
    logic [QF_IDX_W-1:0]   fill;
    logic [QF_IDX_W-1:0]   wr_slot;
    logic [QF_IDX_W-1:0]   rd_slot;
    logic [CNT_W-1:0]      next_out_cnt;
    logic                  hit_data;
    logic                  q_clear;
    logic                  q_start_tx;
    logic                  q_wr;
    logic [BYTE_W-1:0]     q_wdata;
    logic                  q_full;
    logic                  q_empty;
    logic                  push;
    logic                  ovf_evt;
    logic                  host_rd;
    logic                  pop_tx;
    logic                  pop;
    logic                  pop_last;
    logic                  buf_in_ready;
    logic [BUF_W-1:0]      buf_out;
    logic                  buf_out_valid;
    logic                  low_cross;
    logic                  high_cross;
    logic                  flag_ove;
    logic                  flag_lol;
    logic                  flag_hil;
    logic                  last_out;

    // queue data is reachable only with auto-increment addressing
    assign hit_data   = cont_mode && (reg_addr == OFF_DATA);  // [R13]
    assign q_clear    = cmd_valid && (cmd_code == CMD_CLEAR);  // [R1]
    assign q_start_tx = cmd_valid && (cmd_code == CMD_TX);

    // occupancy and slots come from the running counters;
    // a stream past 4096 bytes without a clear would misalign
    assign fill    = fill_of(in_cnt, out_cnt);  // [R15]
    assign wr_slot = slot_of(in_cnt);           // [R15]
    assign rd_slot = slot_of(out_cnt);          // [R15]
    assign q_full  = (fill == FULL_LVL);
    assign q_empty = (fill == 5'h00);

    // during reception the decoder owns the write side
    assign q_wr    = rx_active ? rx_byte_valid : (reg_wr && hit_data);
    assign q_wdata = rx_active ? rx_byte : reg_wdata;
    assign push    = q_wr && !q_full && !q_clear;
    assign ovf_evt = q_wr && q_full;  // [R10]

    // during transmission the transmitter owns the read side
    assign host_rd      = reg_rd && hit_data && !tx_busy && !q_empty;
    assign next_out_cnt = out_cnt + 12'h001;
    assign pop_tx       = tx_busy && !q_empty && buf_in_ready
                          && (out_cnt < tx_len);  // [R7]
    assign pop          = (host_rd || pop_tx) && !q_clear;
    assign pop_last     = pop_tx && (next_out_cnt == tx_len);  // [R8]

    // input byte counter
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            in_cnt <= RST_CNT;
        else if (q_clear)
            in_cnt <= RST_CNT;           // [R1]
        else if (push)
            in_cnt <= in_cnt + 12'h001;  // [R3] [R5]
    end

    // output byte counter
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            out_cnt <= RST_CNT;
        else if (q_clear)
            out_cnt <= RST_CNT;     // [R1]
        else if (pop)
            out_cnt <= next_out_cnt;  // [R4] [R5]
    end

    // byte storage, cleared together with the counters
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < QF_DEPTH; i++)
                store[i] <= RST_BYTE;
        end
        else if (q_clear)
        begin
            for (int i = 0; i < QF_DEPTH; i++)
                store[i] <= RST_BYTE;
        end
        else if (push)
        begin
            store[wr_slot] <= q_wdata;  // [R2]
        end
    end

    // transmit length, high nibble then low byte
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tx_len <= RST_CNT;
        else if (reg_wr && reg_addr == OFF_TXLEN_H)
            tx_len[CNT_W-1:BYTE_W] <= reg_wdata[TXLEN_HI_W-1:0];  // [R14]
        else if (reg_wr && reg_addr == OFF_TXLEN_L)
            tx_len[BYTE_W-1:0] <= reg_wdata;  // [R14]
    end

    // transmission runs from the command to the last byte taken
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tx_busy <= 1'b0;
        else if (q_clear || last_out)
            tx_busy <= 1'b0;
        else if (q_start_tx)
            tx_busy <= 1'b1;
    end

    // two-entry buffer keeps a stalled transmitter from losing bytes
    rtqf_pair_buf u_buf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .flush     (q_clear),
        .in_valid  (pop_tx && !q_clear),
        .in_data   ({pop_last, store[rd_slot]}),
        .in_ready  (buf_in_ready),
        .out_valid (buf_out_valid),
        .out_data  (buf_out),
        .out_ready (tx_ready)
    );

    assign tx_valid = buf_out_valid;
    assign tx_byte  = buf_out[BYTE_W-1:0];
    assign last_out = buf_out_valid && tx_ready && buf_out[BYTE_W];

    // final byte handed to the transmitter
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            tx_last_sent <= 1'b0;
        else
            tx_last_sent <= last_out;  // [R8]
    end

    rtqf_level_watch u_lvl (
        .fill       (fill),
        .clk        (clk),
        .sys_rst    (sys_rst),
        .low_cross  (low_cross),
        .high_cross (high_cross)
    );

    // one pulse per threshold crossing
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            queue_irq <= 1'b0;
        else
            queue_irq <= low_cross || high_cross;  // [R6] [R16]
    end

    // sticky flags; an event in the clear cycle still sets
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            flag_ove <= 1'b0;
        else if (ovf_evt)
            flag_ove <= 1'b1;  // [R10]
        else if (q_clear)
            flag_ove <= 1'b0;  // [R16]
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            flag_lol <= 1'b0;
        else if (low_cross && tx_busy)
            flag_lol <= 1'b1;  // [R11]
        else if (q_clear)
            flag_lol <= 1'b0;  // [R16]
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            flag_hil <= 1'b0;
        else if (high_cross && rx_active)
            flag_hil <= 1'b1;  // [R12]
        else if (q_clear)
            flag_hil <= 1'b0;  // [R16]
    end

    // registered read data, held until the next read
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= RST_BYTE;
        else if (reg_rd)
        begin
            case (reg_addr)
                OFF_DATA:
                    reg_rdata <= host_rd ? store[rd_slot] : RST_BYTE;
                OFF_STATUS:
                begin
                    reg_rdata          <= RST_BYTE;
                    reg_rdata[ST_FHIL] <= flag_hil;
                    reg_rdata[ST_FLOL] <= flag_lol;
                    reg_rdata[ST_FOVE] <= flag_ove;
                    reg_rdata[QF_IDX_W-1:0] <= fill;  // [R9]
                end
                OFF_TXLEN_H:
                    reg_rdata <= {4'h0, tx_len[CNT_W-1:BYTE_W]};
                OFF_TXLEN_L:
                    reg_rdata <= tx_len[BYTE_W-1:0];
                default:
                    reg_rdata <= RST_BYTE;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** rtqf_tx_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
// transmitter model: takes every byte, or one in four while stalling
module rtqf_tx_sink
(
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_ready,
    output logic [7:0]      got [0:15],
    output int              n_got
);
    logic [1:0] ph;

    initial
    begin
        ph = 2'h0;
        n_got = 0;
        tx_ready = 1'b0;
    end

    // slow answers keep the two-entry buffer backed up
    always @(posedge clk)
    begin
        ph <= ph + 2'h1;
        if (tx_valid === 1'b1 && tx_ready)
        begin
            got[n_got[3:0]] <= tx_byte;
            n_got <= n_got + 1;
        end
        tx_ready <= !stall || ph == 2'h3;
    end
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rtqf_pkg::*;
    logic              clk, sys_rst, reg_wr, reg_rd, cont_mode, cmd_valid;
    logic              rx_active, rx_byte_valid, tx_ready, tx_valid, tx_last_sent;
    logic              tx_busy, queue_irq, stall;
    logic [ADDR_W-1:0] reg_addr;
    logic [BYTE_W-1:0] reg_wdata, cmd_code, rx_byte, reg_rdata, tx_byte;
    logic [7:0]        got [0:15];
    int                n_got, n_irq, n_last, failures, checked, i;

    rtqf_queue DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .cont_mode(cont_mode), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .rx_active(rx_active), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .tx_ready(tx_ready),
        .reg_rdata(reg_rdata), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last_sent(tx_last_sent),
        .tx_busy(tx_busy), .queue_irq(queue_irq));
    rtqf_tx_sink u_sink (.clk(clk), .stall(stall), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .got(got), .n_got(n_got));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // pulse counters sample settled values at each edge
    always @(posedge clk)
    begin
        if (queue_irq === 1'b1) n_irq <= n_irq + 1;
        if (tx_last_sent === 1'b1) n_last <= n_last + 1;
    end

    task automatic finish_test();
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // strobes are held one edge, then one idle edge follows
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, exp);
    endtask

    task automatic cmd(input logic [7:0] c);
        @(posedge clk);
        cmd_code <= c;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask

    task automatic rxb(input logic [7:0] d);
        @(posedge clk);
        rx_byte <= d;
        rx_byte_valid <= 1'b1;
        @(posedge clk);
        rx_byte_valid <= 1'b0;
    endtask

    initial
    begin
        #200000;
        failures++;
        finish_test();
    end

    initial
    begin
        {sys_rst, reg_wr, reg_rd, cmd_valid, rx_active, rx_byte_valid, stall} = 7'h40;
        {reg_addr, reg_wdata, cmd_code, rx_byte} = 30'h0;
        cont_mode = 1'b0;
        n_irq = 0;
        n_last = 0;
        failures = 0;
        checked = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd(OFF_STATUS, 8'h00);
        rd(6'h00, 8'h00);
        wr(OFF_DATA, 8'h55);
        rd(OFF_STATUS, 8'h00);
        rd(OFF_DATA, 8'h00);
        @(posedge clk);
        cont_mode <= 1'b1;
        // fill to full, then one too many
        for (i = 0; i < 24; i++) wr(OFF_DATA, 8'(8'h40 + i));
        rd(OFF_STATUS, 8'h18);
        wr(OFF_DATA, 8'hee);
        rd(OFF_STATUS, 8'h38);
        for (i = 0; i < 12; i++) rd(OFF_DATA, 8'(8'h40 + i));
        // refill across the end of storage
        for (i = 0; i < 12; i++) wr(OFF_DATA, 8'(8'h58 + i));
        for (i = 0; i < 24; i++) rd(OFF_DATA, 8'(8'h4c + i));
        rd(OFF_STATUS, 8'h20);
        check(8'(n_irq), 8'h03);
        // transmit more bytes than the length allows, stalling
        cmd(CMD_CLEAR);
        rd(OFF_STATUS, 8'h00);
        wr(OFF_TXLEN_H, 8'h00);
        wr(OFF_TXLEN_L, 8'h08);
        for (i = 0; i < 10; i++) wr(OFF_DATA, 8'(8'h80 + i));
        stall <= 1'b1;
        cmd(CMD_TX);
        repeat (300) if (n_last == 0) @(posedge clk);
        if (n_last == 0)
        begin
            failures++;
            finish_test();
        end
        repeat (4) @(posedge clk);
        check(8'(n_last), 8'h01);
        check(8'(n_got), 8'h08);
        for (i = 0; i < 8; i++) check(got[i], 8'(8'h80 + i));
        rd(OFF_STATUS, 8'h42);
        check(8'(n_irq), 8'h04);
        // reception past the high level and into overflow
        cmd(CMD_CLEAR);
        rx_active <= 1'b1;
        for (i = 0; i < 19; i++) rxb(8'(8'hc0 + i));
        repeat (4) @(posedge clk);
        rd(OFF_STATUS, 8'h93);
        for (i = 0; i < 6; i++) rxb(8'(8'hd3 + i));
        rd(OFF_STATUS, 8'hb8);
        @(posedge clk);
        rx_active <= 1'b0;
        rd(OFF_DATA, 8'hc0);
        check(8'(n_irq), 8'h05);
        finish_test();
    end
endmodule

bind rtqf_queue rtqf_props u_props (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rx_active(rx_active),
    .rx_byte_valid(rx_byte_valid), .tx_ready(tx_ready), .reg_rdata(reg_rdata), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_last_sent(tx_last_sent), .tx_busy(tx_busy), .queue_irq(queue_irq));
`default_nettype wire
